// ==== wds_pkg.sv ====
`default_nettype none
package wds_pkg;
  // ----------------------------------------------------------------
  // Bus addresses and register fields
  // ----------------------------------------------------------------
  localparam logic [7:0] WDS_ADDR_CMD   = 8'h7a;
  localparam logic [7:0] WDS_ADDR_SEL   = 8'h7b;
  localparam logic [7:0] WDS_ADDR_RD1   = 8'hfa;
  localparam logic [7:0] WDS_ADDR_RD2   = 8'hfb;
  localparam int         WDS_SUB_LSB    = 0;
  localparam int         WDS_SECT_BIT   = 3;
  localparam int         WDS_MODE_MAXH  = 0;
  localparam int         WDS_MODE_FRZ   = 1;
  localparam int         WDS_MODE_DIFF  = 2;
  localparam int         WDS_MODE_DET   = 3;
  localparam int         WDS_MODE_VIEW  = 5;
  localparam logic [2:0] WDS_SUB_MODE   = 3'h0;
  localparam logic [2:0] WDS_SUB_MK1_LO = 3'h1;
  localparam logic [2:0] WDS_SUB_MK1_HI = 3'h2;
  localparam logic [2:0] WDS_SUB_MK2_LO = 3'h3;
  localparam logic [2:0] WDS_SUB_MK2_HI = 3'h4;
  localparam logic [2:0] WDS_SUB_PTR_LO = 3'h5;
  localparam logic [2:0] WDS_SUB_PTR_HI = 3'h6;
  localparam logic [7:0] WDS_MODE_RST   = 8'h00;
  localparam logic [7:0] WDS_SEL_RST    = 8'h00;
  localparam logic [7:0] WDS_THR_RST    = 8'h80;
  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int         WDS_POINTS     = 500;
  localparam int         WDS_MERGED     = 1000;
  localparam int         WDS_CNT_W      = 17;
  localparam int         WDS_DIV_STEPS  = 25;
  localparam int         WDS_FIFO_DEPTH = 8;
  localparam int         WDS_CLK_HZ     = 10_000_000;
  // Detect method and view encodings
  localparam logic [1:0] WDS_DET_SPLIT  = 2'h0;
  localparam logic [1:0] WDS_DET_PEAK   = 2'h1;
  localparam logic [1:0] WDS_DET_AVG    = 2'h2;
  localparam logic [1:0] WDS_VIEW_BOTH  = 2'h0;
  localparam logic [1:0] WDS_VIEW_A     = 2'h1;
  localparam logic [1:0] WDS_VIEW_B     = 2'h2;

  typedef struct packed {
    logic [8:0] x;
    logic [7:0] y;
  } wds_sample_t;

  typedef struct packed {
    logic [8:0] x;
    logic [7:0] peak;
    logic [7:0] mean;
  } wds_point_t;

  typedef struct packed {
    logic [9:0] x;
    logic [7:0] y;
    logic       trace;
    logic       marker;
    logic       update;
  } wds_disp_t;

  function automatic logic wds_is_mapped(input logic [7:0] a);
    wds_is_mapped = (a == WDS_ADDR_CMD) || (a == WDS_ADDR_SEL) || (a == WDS_ADDR_RD1) || (a == WDS_ADDR_RD2);
  endfunction : wds_is_mapped
endpackage : wds_pkg
`default_nettype wire

// ==== wds_fifo.sv ====
`default_nettype none
module wds_fifo
  import wds_pkg::*;
#(
  parameter int W     = 17,
  parameter int DEPTH = WDS_FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Fill side
  input  wire logic [W-1:0] in_data_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  // Drain side
  output logic [W-1:0]      out_data_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem[rp_r];
  assign cnt_nxt       = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wp_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wp_r         <= '0;
      rp_r         <= '0;
      cnt_r        <= '0;
      in_ready_out <= 1'b0;
    end
    else
    begin
      if (push) wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r        <= cnt_nxt;
      // Ready is registered so the source sees back-pressure from a flop
      in_ready_out <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end

  property p_no_overflow;
    @(posedge clk_in) disable iff (rst_in) (cnt_r == (AW+1)'(DEPTH)) |-> !in_ready_out;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo ready while full");

  property p_count_up;
    @(posedge clk_in) disable iff (rst_in) (push && !pop) |=> (cnt_r == $past(cnt_r) + 1'b1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("fifo count did not rise on push");
endmodule : wds_fifo
`default_nettype wire

// ==== wds_reduce.sv ====
`default_nettype none
module wds_reduce
  import wds_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Raw samples
  input  wire wds_sample_t smp_in,
  input  wire logic        smp_valid_in,
  output logic             smp_ready_out,
  // One reduced point per sweep position
  output wds_point_t       pt_out,
  output logic             pt_valid_out
);
  typedef enum logic [1:0] {RD_ACC = 2'b00, RD_DIV = 2'b01, RD_EMIT = 2'b11} wds_rd_t;
  localparam logic [WDS_CNT_W:0] CNT_MAX = (WDS_CNT_W+1)'(1) << WDS_CNT_W;
  wds_rd_t              st_r;
  logic                 have_r;
  logic [8:0]           cur_x_r;
  logic [7:0]           peak_r;
  logic [24:0]          sum_r, num_r, q_r;
  logic [WDS_CNT_W:0]   cnt_r, den_r;
  logic [WDS_CNT_W+1:0] rem_r, rem_s;
  logic [4:0]           step_r;
  logic                 newx, take, ge;

  assign newx          = have_r && (smp_in.x != cur_x_r);
  // A new position stalls the input until the old one is divided out
  assign smp_ready_out = (st_r == RD_ACC) && !newx;
  assign take          = smp_valid_in && smp_ready_out;
  assign rem_s         = {rem_r[WDS_CNT_W:0], num_r[24]};
  assign ge            = rem_s >= {1'b0, den_r};
  assign pt_valid_out  = (st_r == RD_EMIT);
  assign pt_out.x      = cur_x_r;
  assign pt_out.peak   = peak_r;
  assign pt_out.mean   = (|q_r[24:8]) ? 8'hff : q_r[7:0];

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r    <= RD_ACC;
      have_r  <= 1'b0;
      cur_x_r <= '0;
      peak_r  <= '0;
      sum_r   <= '0;
      cnt_r   <= '0;
      num_r   <= '0;
      den_r   <= '0;
      rem_r   <= '0;
      q_r     <= '0;
      step_r  <= '0;
    end
    else
    begin
      case (st_r)
        RD_ACC:
        begin
          if (take && !have_r)
          begin
            have_r  <= 1'b1;
            cur_x_r <= smp_in.x;
            peak_r  <= smp_in.y;
            sum_r   <= {17'h0, smp_in.y};
            cnt_r   <= (WDS_CNT_W+1)'(1);
          end
          else if (take)
          begin
            if (smp_in.y > peak_r) peak_r <= smp_in.y;
            // Past the counter limit only the peak keeps learning
            if (cnt_r != CNT_MAX)
            begin
              sum_r <= sum_r + {17'h0, smp_in.y};
              cnt_r <= cnt_r + 1'b1;
            end
          end
          else if (smp_valid_in && newx)
          begin
            num_r  <= sum_r;
            den_r  <= cnt_r;
            rem_r  <= '0;
            q_r    <= '0;
            step_r <= '0;
            st_r   <= RD_DIV;
          end
        end
        RD_DIV:
        begin
          rem_r  <= ge ? rem_s - {1'b0, den_r} : rem_s;
          q_r    <= {q_r[23:0], ge};
          num_r  <= {num_r[23:0], 1'b0};
          step_r <= step_r + 1'b1;
          if (step_r == 5'(WDS_DIV_STEPS-1)) st_r <= RD_EMIT;
        end
        RD_EMIT:
        begin
          have_r <= 1'b0;
          st_r   <= RD_ACC;
        end
        default: st_r <= RD_ACC;
      endcase
    end
  end

  property p_div_len;
    @(posedge clk_in) disable iff (rst_in) (st_r == RD_DIV && $past(st_r) == RD_ACC) |-> ##25 (st_r == RD_EMIT);
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length wrong");

  property p_mean_le_peak;
    @(posedge clk_in) disable iff (rst_in) pt_valid_out |-> (pt_out.mean <= pt_out.peak);
  endproperty
  a_mean_le_peak: assert property (p_mean_le_peak) else $error("mean above peak");
endmodule : wds_reduce
`default_nettype wire

// ==== wds_storage.sv ====
`default_nettype none
// Notes on behaviour
// - Two banks, 500 points each
// - Two write and two read addresses
// - Section bit picks responding register set
// - Command write split eight ways by select
// - Max hold keeps largest value per point
// - Freeze stops all updates to bank A
// - Difference: A frozen, output B minus A
// - Split: above cursor peak, below average
// - View modes show selected bank or banks
// - Sweep position is the table index
// - Stream stored values back with positions
// - Two user markers plus update marker
// - B every sweep, A unless frozen
// - In view both, the banks interleave into 1000 positions unless frozen
// - Per point keep peak or mean
// - Everything runs on one clock
module wds_storage
  import wds_pkg::*;
#(
  parameter int POINTS = WDS_POINTS
)(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Instrument bus
  input  wire logic [7:0]  bus_addr_in,
  input  wire logic [7:0]  bus_wdata_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  output logic [7:0]       bus_rdata_out,
  output logic             bus_ack_out,
  // Digitized samples
  input  wire wds_sample_t smp_in,
  input  wire logic        smp_valid_in,
  output logic             smp_ready_out,
  // Redraw stream
  output logic [9:0]       disp_x_out,
  output logic [7:0]       disp_y_out,
  output logic             disp_trace_out,
  output logic             disp_marker_out,
  output logic             disp_update_out,
  output logic [7:0]       cursor_level_out
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_TRACE1 = 2'b01, DS_TRACE2 = 2'b11} wds_ds_t;

  logic [7:0]  sel_r, mode_r, thr_r;
  logic [8:0]  mk1_r, mk2_r, ptr_r, acq_x_r;
  logic        sect_vert;
  logic [2:0]  sub;
  logic        wr_cmd, wr_sel;
  logic        maxh, frz, diff;
  logic [1:0]  detect_method_select, view;

  assign sub       = sel_r[WDS_SUB_LSB +: 3];
  assign sect_vert = sel_r[WDS_SECT_BIT];
  assign wr_cmd    = bus_wr_in && (bus_addr_in == WDS_ADDR_CMD);
  assign wr_sel    = bus_wr_in && (bus_addr_in == WDS_ADDR_SEL);
  assign maxh      = mode_r[WDS_MODE_MAXH];
  assign diff      = mode_r[WDS_MODE_DIFF];
  assign frz       = mode_r[WDS_MODE_FRZ] || diff;
  assign detect_method_select = mode_r[WDS_MODE_DET +: 2];
  assign view      = mode_r[WDS_MODE_VIEW +: 2];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sel_r  <= WDS_SEL_RST;
      mode_r <= WDS_MODE_RST;
      thr_r  <= WDS_THR_RST;
      mk1_r  <= '0;
      mk2_r  <= '0;
      ptr_r  <= '0;
    end
    else
    begin
      if (wr_sel) sel_r <= bus_wdata_in;
      if (wr_cmd && sect_vert)
      begin
        thr_r <= bus_wdata_in;
      end
      else if (wr_cmd)
      begin
        case (sub)
          WDS_SUB_MODE:   mode_r <= bus_wdata_in;
          WDS_SUB_MK1_LO: mk1_r[7:0] <= bus_wdata_in;
          WDS_SUB_MK1_HI: mk1_r[8] <= bus_wdata_in[0];
          WDS_SUB_MK2_LO: mk2_r[7:0] <= bus_wdata_in;
          WDS_SUB_MK2_HI: mk2_r[8] <= bus_wdata_in[0];
          WDS_SUB_PTR_LO: ptr_r[7:0] <= bus_wdata_in;
          WDS_SUB_PTR_HI: ptr_r[8] <= bus_wdata_in[0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  wds_sample_t fifo_data;
  logic        fifo_valid, red_ready;
  wds_point_t  pt;
  logic        pt_valid;

  wds_fifo #(.W($bits(wds_sample_t)), .DEPTH(WDS_FIFO_DEPTH)) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (rst_in),
    .in_data_in    (smp_in),
    .in_valid_in   (smp_valid_in),
    .in_ready_out  (smp_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (red_ready)
  );

  wds_reduce u_reduce (
    .clk_in        (sys_clk_in),
    .rst_in        (rst_in),
    .smp_in        (fifo_data),
    .smp_valid_in  (fifo_valid),
    .smp_ready_out (red_ready),
    .pt_out        (pt),
    .pt_valid_out  (pt_valid)
  );

  // ----------------------------------------------------------------
  // Waveform banks
  // ----------------------------------------------------------------
  // two 500-point banks
  logic [7:0] bank_a [POINTS];
  logic [7:0] bank_b [POINTS];
  logic [7:0] y_new, old_a, old_b, chk_a_r, chk_b_r;
  logic       pt_ok;

  assign pt_ok = pt_valid && (int'(pt.x) < POINTS);
  assign old_a = bank_a[pt_ok ? pt.x : 9'h0];
  assign old_b = bank_b[pt_ok ? pt.x : 9'h0];

  always_comb
  begin
    case (detect_method_select)
      WDS_DET_PEAK: y_new = pt.peak;
      WDS_DET_AVG:  y_new = pt.mean;
      default:      y_new = (pt.peak > thr_r) ? pt.peak : pt.mean;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (pt_ok)
    begin
      if (!frz) bank_a[pt.x] <= (maxh && old_a > y_new) ? old_a : y_new;
      bank_b[pt.x] <= (maxh && old_b > y_new) ? old_b : y_new;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      acq_x_r <= '0;
      chk_a_r <= '0;
      chk_b_r <= '0;
    end
    else if (pt_ok)
    begin
      acq_x_r <= pt.x;
      chk_a_r <= old_a;
      chk_b_r <= old_b;
    end
  end

  // ----------------------------------------------------------------
  // Bus reads
  // ----------------------------------------------------------------
  logic [8:0] rptr;
  logic [7:0] rd_val;
  logic       rd_hit;

  assign rptr   = (int'(ptr_r) < POINTS) ? ptr_r : 9'h0;
  assign rd_hit = bus_rd_in && ((bus_addr_in == WDS_ADDR_RD1) || (bus_addr_in == WDS_ADDR_RD2));

  always_comb
  begin
    case ({sect_vert, bus_addr_in == WDS_ADDR_RD2})
      2'b00:   rd_val = acq_x_r[7:0];
      2'b01:   rd_val = {5'h0, frz, maxh, acq_x_r[8]};
      2'b10:   rd_val = bank_a[rptr];
      default: rd_val = bank_b[rptr];
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bus_rdata_out <= '0;
      bus_ack_out   <= 1'b0;
    end
    else
    begin
      bus_ack_out <= (bus_wr_in || bus_rd_in) && wds_is_mapped(bus_addr_in);
      if (rd_hit) bus_rdata_out <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Redraw scanner
  // ----------------------------------------------------------------
  wds_ds_t    ds_r;
  logic [9:0] idx_r, idx_last;
  logic       merged, two_tr, show_b;
  logic [8:0] pi;
  logic [7:0] va, vb;
  wds_disp_t  dn;

  assign merged   = (view == WDS_VIEW_BOTH) && !frz;
  assign two_tr   = (view == WDS_VIEW_BOTH) && frz && !diff;
  assign idx_last = merged ? 10'(WDS_MERGED - 1) : 10'(POINTS - 1);
  // A mode change can leave the index past a short pass for one cycle
  assign pi       = merged ? idx_r[9:1] : ((idx_r < 10'(POINTS)) ? idx_r[8:0] : 9'h0);
  assign show_b   = merged ? idx_r[0] : ((ds_r == DS_TRACE2) || (view == WDS_VIEW_B));
  assign va       = bank_a[pi];
  assign vb       = bank_b[pi];

  always_comb
  begin
    dn        = '0;
    dn.x      = {pi, show_b};
    dn.trace  = (ds_r == DS_TRACE2);
    dn.marker = (pi == mk1_r) || (pi == mk2_r);
    dn.update = (pi == acq_x_r);
    if (diff)
    begin
      dn.y = (vb > va) ? vb - va : 8'h00;
    end
    else
    begin
      dn.y = show_b ? vb : va;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ds_r  <= DS_IDLE;
      idx_r <= '0;
    end
    else
    begin
      case (ds_r)
        DS_IDLE: ds_r <= DS_TRACE1;
        DS_TRACE1, DS_TRACE2:
        begin
          if (idx_r >= idx_last)
          begin
            idx_r <= '0;
            ds_r  <= (ds_r == DS_TRACE1 && two_tr) ? DS_TRACE2 : DS_TRACE1;
          end
          else
          begin
            idx_r <= idx_r + 1'b1;
          end
        end
        default: ds_r <= DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      disp_x_out       <= '0;
      disp_y_out       <= '0;
      disp_trace_out   <= 1'b0;
      disp_marker_out  <= 1'b0;
      disp_update_out  <= 1'b0;
      cursor_level_out <= WDS_THR_RST;
    end
    else
    begin
      disp_x_out       <= dn.x;
      disp_y_out       <= dn.y;
      disp_trace_out   <= dn.trace;
      disp_marker_out  <= dn.marker && (ds_r != DS_IDLE);
      disp_update_out  <= dn.update && (ds_r != DS_IDLE);
      cursor_level_out <= thr_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_freeze_a;
    @(posedge sys_clk_in) disable iff (rst_in) (pt_ok && frz) |=> (bank_a[acq_x_r] == chk_a_r);
  endproperty
  a_freeze_a: assert property (p_freeze_a) else $error("frozen bank A changed");

  property p_maxhold_b;
    @(posedge sys_clk_in) disable iff (rst_in) (pt_ok && maxh) |=> (bank_b[acq_x_r] >= chk_b_r);
  endproperty
  a_maxhold_b: assert property (p_maxhold_b) else $error("max hold lost a peak");

  property p_sel_write;
    @(posedge sys_clk_in) disable iff (rst_in) wr_sel |=> (sel_r == $past(bus_wdata_in));
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select write not stored");

  property p_read_clean;
    @(posedge sys_clk_in) disable iff (rst_in) (bus_rd_in && !bus_wr_in) |=> $stable(mode_r) && $stable(sel_r);
  endproperty
  a_read_clean: assert property (p_read_clean) else $error("read changed mode");

  property p_ack;
    @(posedge sys_clk_in) disable iff (rst_in) ((bus_rd_in || bus_wr_in) && wds_is_mapped(bus_addr_in)) |=> bus_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("mapped access not acknowledged");

  property p_x_range;
    @(posedge sys_clk_in) disable iff (rst_in) ##1 (disp_x_out < 10'(WDS_MERGED));
  endproperty
  a_x_range: assert property (p_x_range) else $error("redraw position out of range");
endmodule : wds_storage
`default_nettype wire

// ==== wds_proc_model.sv ====
`default_nettype none
module wds_proc_model (
  // Clock
  input  wire logic       clk_in,
  // Instrument bus
  output var  logic [7:0] addr_out,
  output var  logic [7:0] wdata_out,
  output var  logic       wr_out,
  output var  logic       rd_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       ack_in
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // one-cycle strobe, address held until ack
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    int i;
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= w;
    rd_out    <= !w;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    // Released data is scrambled so a stale value cannot pass for a fresh one
    wdata_out <= ~d;
    ok = 1'b0;
    q  = 8'h00;
    for (i = 0; i < 3 && !ok; i++)
    begin
      @(posedge clk_in);
      ok = (ack_in === 1'b1);
      q  = rdata_in;
    end
  endtask : xfer
endmodule : wds_proc_model
`default_nettype wire

// ==== test_waveform_digital_storage_control.sv ====
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_waveform_digital_storage_control
  import wds_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  addr, wdata, rdata, cursor;
  logic        bus_wr, rd, ack, ready, dt, dm, du;
  logic        valid   = 1'b0;
  wds_sample_t smp     = '0;
  logic [9:0]  dx;
  logic [7:0]  dy;
  int          n_fail = 0, n_checks = 0, cyc = 0, seed = 82990;
  int          bank_a [500], bank_b [500];
  int          cur_x = -1, pk, sum, cnt, thr_m = 128, det_m, mh_m, frz_m, saw_full;

  always #50 sys_clk = ~sys_clk;

  wds_storage i_wds_storage (.sys_clk_in(sys_clk), .rst_in(rst), .bus_addr_in(addr), .bus_wdata_in(wdata),
    .bus_wr_in(bus_wr), .bus_rd_in(rd), .bus_rdata_out(rdata), .bus_ack_out(ack), .smp_in(smp),
    .smp_valid_in(valid), .smp_ready_out(ready), .disp_x_out(dx), .disp_y_out(dy), .disp_trace_out(dt),
    .disp_marker_out(dm), .disp_update_out(du), .cursor_level_out(cursor));
  wds_proc_model i_wds_proc_model (.clk_in(sys_clk), .addr_out(addr), .wdata_out(wdata), .wr_out(bus_wr),
    .rd_out(rd), .rdata_in(rdata), .ack_in(ack));

  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Reference model: one value per point, written when x moves on
  // ------------------------------------------------------------
  function automatic void commit();
    int v;
    if (cur_x < 0 || cur_x >= 500)
      return;
    v = (det_m == 1 || (det_m == 0 && pk > thr_m)) ? pk : sum / cnt;
    if (!frz_m)
      bank_a[cur_x] = (mh_m && bank_a[cur_x] > v) ? bank_a[cur_x] : v;
    bank_b[cur_x] = (mh_m && bank_b[cur_x] > v) ? bank_b[cur_x] : v;
  endfunction : commit

  task automatic put(input int x, input int y);
    int i;
    if (x != cur_x)
    begin
      commit();
      cur_x = x;
      pk = 0;
      sum = 0;
      cnt = 0;
    end
    pk = (y > pk) ? y : pk;
    sum += y;
    cnt++;
    smp   <= {9'(x), 8'(y)};
    valid <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
      saw_full |= (ready !== 1'b1);
    end while (ready !== 1'b1 && i < 300);
    `CHK(ready, 1'b1)
  endtask : put

  task automatic ptwo(input int x, input int y);
    put(x, y);
    put(x, y);
  endtask : ptwo

  // Two samples with an even sum so the mean is exact
  task automatic rpt(input int x);
    int r, s;
    r = $random(seed) & 127;
    s = $random(seed) & 31;
    put(x, r);
    put(x, r + 2 * s);
  endtask : rpt

  // An off-table position pushes the last real point out
  task automatic flush;
    put(511, 0);
    valid <= 1'b0;
    repeat (80) @(posedge sys_clk);
  endtask : flush

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       ok;
    i_wds_proc_model.xfer(1'b1, a, d, q, ok);
    `CHK(ok, 1'b1)
  endtask : wr

  task automatic rdv(input logic [7:0] a, output logic [7:0] q);
    logic ok;
    i_wds_proc_model.xfer(1'b0, a, 8'h00, q, ok);
    `CHK(ok, 1'b1)
  endtask : rdv

  task automatic mode(input logic [7:0] m);
    wr(WDS_ADDR_SEL, 8'h00);
    wr(WDS_ADDR_CMD, m);
    mh_m  = m[0];
    frz_m = m[1] | m[2];
    det_m = m[4:3];
  endtask : mode

  task automatic chk_pt(input int x);
    logic [7:0] q;
    wr(WDS_ADDR_SEL, {5'h00, WDS_SUB_PTR_LO});
    wr(WDS_ADDR_CMD, 8'(x));
    wr(WDS_ADDR_SEL, {5'h00, WDS_SUB_PTR_HI});
    wr(WDS_ADDR_CMD, 8'(x >> 8));
    wr(WDS_ADDR_SEL, 8'h08);
    rdv(WDS_ADDR_RD1, q);
    `CHK(q, 8'(bank_a[x]))
    rdv(WDS_ADDR_RD2, q);
    `CHK(q, 8'(bank_b[x]))
  endtask : chk_pt

  // Redraw of point 7, which both user markers sit on
  task automatic scan(input logic [9:0] xv, input int y);
    int i;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end while (dx !== xv && i < 3000);
    `CHK(dx, xv)
    `CHK(dy, 8'(y))
    `CHK(dm, 1'b1)
    // Point 7 is also the last one acquired
    `CHK(du, 1'b1)
  endtask : scan

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] q;
    logic       ok;
    int         rx;
    repeat (6) @(posedge sys_clk);
    `CHK(cursor, WDS_THR_RST)
    `CHK(ready, 1'b0)
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wr(WDS_ADDR_SEL, 8'h08);
    wr(WDS_ADDR_CMD, 8'h60);
    thr_m = 96;
    // Cursor output is one more flop behind the threshold register
    @(posedge sys_clk);
    `CHK(cursor, 8'h60)
    i_wds_proc_model.xfer(1'b1, 8'h7c, 8'h11, q, ok);
    `CHK(ok, 1'b0)
    for (int s = 1; s <= 4; s++)
    begin
      wr(WDS_ADDR_SEL, 8'(s));
      wr(WDS_ADDR_CMD, (s % 2) ? 8'h07 : 8'h00);
    end
    for (int k = 0; k < 3; k++)
    begin
      mode(8'(k << 3));
      rx = 3 + ($random(seed) & 255);
      rpt(0);
      rpt(499);
      rpt(rx);
      flush();
      chk_pt(0);
      chk_pt(499);
      chk_pt(rx);
    end
    mode(8'h08);
    ptwo(7, 100);
    flush();
    mode(8'h09);
    ptwo(7, 30);
    flush();
    chk_pt(7);
    mode(8'h0a);
    ptwo(7, 50);
    flush();
    chk_pt(7);
    scan(10'd15, bank_b[7]);
    `CHK(dt, 1'b1)
    wr(WDS_ADDR_SEL, 8'h00);
    rdv(WDS_ADDR_RD2, q);
    `CHK(q[2:1], 2'b10)
    rdv(WDS_ADDR_RD1, q);
    `CHK(q, 8'h07)
    mode(8'h4c);
    ptwo(7, 120);
    flush();
    chk_pt(7);
    scan(10'd15, bank_b[7] - bank_a[7]);
    `CHK(dt, 1'b0)
    mode(8'h28);
    scan(10'd14, bank_a[7]);
    mode(8'h08);
    scan(10'd15, bank_b[7]);
    scan(10'd14, bank_a[7]);
    saw_full = 0;
    for (int i = 0; i < 12; i++)
      put(21, 77);
    flush();
    `CHK(saw_full != 0, 1'b1)
    chk_pt(21);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(cursor, WDS_THR_RST)
    rst <= 1'b0;
    @(posedge sys_clk);
    wr(WDS_ADDR_SEL, 8'h00);
    rdv(WDS_ADDR_RD2, q);
    `CHK(q[2:1], 2'b00)
    tally_and_finish();
  end
endmodule : test_waveform_digital_storage_control
`default_nettype wire
